//--- rtl/ipv4_tx_pkg.sv
/*
 * constants, codes and state encoding for the ipv4 transmit request handler.
 * assumes the frame envelope (delimiter, length, checksum, frame type) has
 * been stripped upstream; the byte stream starts at the frame id byte.
 */
// Contract
// - no matching socket for a new destination: open one before sending payload.
// - network data arriving on an open socket goes to the host as receive data.
// - frame id echoed in status; id 0 suppresses the status entirely.
// - source port 0: reuse socket matching destination, else open a new one.
// - nonzero source port: use only a full match, else status reports error.
// - protocol byte 0 udp, 1 tcp, 4 tls; that transport is opened.
// - tls connections use the first tls profile slot.
// - option bit 1 set closes tcp socket after sending; clear leaves it open.
// - the close option bit is ignored for udp.
// - payload is variable, at most 1500 bytes; device accepts up to that for tcp and tls, but caps udp payload at 512 bytes.
package ipv4_tx_pkg;
	localparam logic [7:0] proto_udp = 8'h00;
	localparam logic [7:0] proto_tcp = 8'h01;
	localparam logic [7:0] proto_tls = 8'h04;
	localparam int opt_close_bit = 1;
	localparam logic [1:0] tls_profile_first = 2'h0;
	localparam logic [10:0] max_payload = 11'h5dc;
	localparam logic [10:0] max_udp_payload = 11'h200;
	// header byte positions, counted from the frame id byte
	localparam logic [3:0] pos_id = 4'h0;
	localparam logic [3:0] pos_addr_last = 4'h4;
	localparam logic [3:0] pos_dport_last = 4'h6;
	localparam logic [3:0] pos_sport_last = 4'h8;
	localparam logic [3:0] pos_proto = 4'h9;
	localparam logic [3:0] pos_opts = 4'ha;
	// status codes
	localparam logic [7:0] st_ok = 8'h00;
	localparam logic [7:0] st_no_socket = 8'h01;
	localparam logic [7:0] st_too_long = 8'h02;
	localparam logic [7:0] st_bad_proto = 8'h03;
	localparam logic [7:0] st_open_fail = 8'h04;
	localparam logic [7:0] st_short_frame = 8'h05;
	localparam logic [7:0] st_no_free = 8'h06;
	typedef enum logic [2:0] {
		s_idle = 3'h0,
		s_hdr = 3'h1,
		s_lookup = 3'h3,
		s_open = 3'h2,
		s_payload = 3'h6,
		s_close = 3'h7,
		s_status = 3'h5,
		s_drain = 3'h4
	} state_type;
endpackage : ipv4_tx_pkg

//--- rtl/sock_slot.sv
/*
 * one socket table entry: remembers an open socket's endpoints and answers
 * a match query. assumes alloc and free are never asserted together.
 */
`timescale 1ns/1ps
`default_nettype none
module sock_slot import ipv4_tx_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic alloc,
	input wire logic free,
	input wire logic [31:0] wr_addr,
	input wire logic [15:0] wr_dport,
	input wire logic [15:0] wr_sport,
	input wire logic [31:0] q_addr,
	input wire logic [15:0] q_dport,
	input wire logic [15:0] q_sport,
	output logic in_use,
	output logic hit
);
	typedef struct packed {
		logic used;
		logic [31:0] addr;
		logic [15:0] dport;
		logic [15:0] sport;
	} slot_type;
	slot_type cur_ff, nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		if (alloc) begin
			nxt_cur.used = 1'b1;
			nxt_cur.addr = wr_addr;
			nxt_cur.dport = wr_dport;
			nxt_cur.sport = wr_sport;
		end else if (free) begin
			nxt_cur.used = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cur_ff <= '0;
		end else if (ce) begin
			cur_ff <= nxt_cur;
		end
	end

	assign in_use = cur_ff.used;
	// zero source port matches destination only, else all three must match
	assign hit = cur_ff.used && cur_ff.addr == q_addr &&
		cur_ff.dport == q_dport &&
		(q_sport == 16'h0000 || cur_ff.sport == q_sport);
endmodule : sock_slot
`default_nettype wire

//--- rtl/ipv4_transmit_request_handler.sv
/*
 * parses ipv4 transmit request frames, picks or opens a socket, forwards
 * the payload, optionally closes it, and reports status; also passes socket
 * receive data to the host. assumes the network stack answers open and
 * close requests and handles the client connection idle timeout itself.
 */
`timescale 1ns/1ps
`default_nettype none
module ipv4_transmit_request_handler import ipv4_tx_pkg::*; #(
	parameter int num_sock = 4,
	parameter int sw = (num_sock > 1) ? $clog2(num_sock) : 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic net_open_req,
	output logic [31:0] net_open_addr,
	output logic [15:0] net_open_port,
	output logic [7:0] net_open_proto,
	output logic net_open_tls,
	output logic [1:0] net_open_tls_profile,
	input wire logic net_open_done,
	input wire logic net_open_ok,
	input wire logic [15:0] net_open_local_port,
	output logic net_tx_valid,
	input wire logic net_tx_ready,
	output logic [7:0] net_tx_data,
	output logic net_tx_last,
	output logic [sw-1:0] net_tx_sock,
	output logic net_tx_abort,
	output logic net_close_req,
	input wire logic net_close_done,
	input wire logic net_sock_closed,
	input wire logic [sw-1:0] net_sock_closed_idx,
	input wire logic net_rx_valid,
	output logic net_rx_ready,
	input wire logic [7:0] net_rx_data,
	input wire logic net_rx_last,
	input wire logic [sw-1:0] net_rx_sock,
	output logic host_rx_valid,
	input wire logic host_rx_ready,
	output logic [7:0] host_rx_data,
	output logic host_rx_last,
	output logic [sw-1:0] host_rx_sock,
	output logic stat_valid,
	input wire logic stat_ready,
	output logic [7:0] stat_frame_id,
	output logic [7:0] stat_code
);
	typedef struct packed {
		state_type st;
		logic [7:0] fid;
		logic [31:0] addr;
		logic [15:0] dport;
		logic [15:0] sport;
		logic [7:0] proto;
		logic [7:0] opts;
		logic [3:0] pos;
		logic [10:0] cnt;
		logic [sw-1:0] sock;
		logic [7:0] code;
		logic ended;
		logic txv;
		logic [7:0] txd;
		logic txl;
		logic abort;
		logic rxv;
		logic [7:0] rxd;
		logic rxl;
		logic [sw-1:0] rxs;
	} ctl_type;
	ctl_type r_ff, nxt_r;

	logic [num_sock-1:0] used, hits, alloc_v, free_v;
	logic any_hit, any_free;
	logic [sw-1:0] hit_idx, free_idx;
	logic in_take, tx_take, rx_take, close_wanted, opening_ok;
	logic [10:0] limit;

	////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < num_sock; gi++) begin : g_slot
			sock_slot u_slot (
				.clk(clk),
				.rst(rst),
				.ce(ce),
				.alloc(alloc_v[gi]),
				.free(free_v[gi]),
				.wr_addr(r_ff.addr),
				.wr_dport(r_ff.dport),
				.wr_sport(net_open_local_port),
				.q_addr(r_ff.addr),
				.q_dport(r_ff.dport),
				.q_sport(r_ff.sport),
				.in_use(used[gi]),
				.hit(hits[gi])
			);
		end
	endgenerate

	always_comb begin
		any_hit = 1'b0;
		any_free = 1'b0;
		hit_idx = '0;
		free_idx = '0;
		for (int i = num_sock - 1; i >= 0; i--) begin
			if (hits[i]) begin
				any_hit = 1'b1;
				hit_idx = sw'(i);
			end
			if (!used[i]) begin
				any_free = 1'b1;
				free_idx = sw'(i);
			end
		end
	end

	assign opening_ok = r_ff.st == s_open && net_open_done && net_open_ok;
	always_comb begin
		for (int i = 0; i < num_sock; i++) begin
			alloc_v[i] = opening_ok && r_ff.sock == sw'(i);
			free_v[i] = !alloc_v[i] &&
				((r_ff.st == s_close && net_close_done &&
				r_ff.sock == sw'(i)) ||
				(net_sock_closed && net_sock_closed_idx == sw'(i)));
		end
	end

	////////////////////////////////////////////////////////////////////////
	// udp payload capped tighter; enforced here so a bad host is reported
	assign limit = (r_ff.proto == proto_udp) ? max_udp_payload
		: max_payload;
	// close option only counts for tcp and tls
	assign close_wanted = r_ff.proto != proto_udp &&
		r_ff.opts[opt_close_bit];
	assign in_ready = r_ff.st == s_hdr || r_ff.st == s_drain ||
		(r_ff.st == s_payload && !r_ff.ended &&
		(!r_ff.txv || net_tx_ready));
	assign in_take = in_valid && in_ready;
	assign tx_take = r_ff.txv && net_tx_ready;
	assign net_rx_ready = !r_ff.rxv || host_rx_ready;
	assign rx_take = net_rx_valid && net_rx_ready;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.abort = 1'b0;
		if (tx_take) begin
			nxt_r.txv = 1'b0;
		end
		// receive data only forwarded while its socket is open
		if (r_ff.rxv && host_rx_ready) begin
			nxt_r.rxv = 1'b0;
		end
		if (rx_take) begin
			nxt_r.rxv = used[net_rx_sock];
			nxt_r.rxd = net_rx_data;
			nxt_r.rxl = net_rx_last;
			nxt_r.rxs = net_rx_sock;
		end
		case (r_ff.st)
			s_idle: begin
				nxt_r.pos = pos_id;
				nxt_r.cnt = '0;
				nxt_r.ended = 1'b0;
				nxt_r.code = st_ok;
				nxt_r.opts = '0;
				nxt_r.st = s_hdr;
			end
			s_hdr: begin
				if (in_take) begin
					nxt_r.pos = r_ff.pos + 4'h1;
					// big endian fields shift in msb first
					if (r_ff.pos == pos_id) begin
						nxt_r.fid = in_data;
					end else if (r_ff.pos <= pos_addr_last) begin
						nxt_r.addr = {r_ff.addr[23:0], in_data};
					end else if (r_ff.pos <= pos_dport_last) begin
						nxt_r.dport = {r_ff.dport[7:0], in_data};
					end else if (r_ff.pos <= pos_sport_last) begin
						nxt_r.sport = {r_ff.sport[7:0], in_data};
					end else if (r_ff.pos == pos_proto) begin
						nxt_r.proto = in_data;
					end else begin
						nxt_r.opts = in_data;
					end
					if (r_ff.pos == pos_opts) begin
						nxt_r.ended = in_last;
						nxt_r.st = s_lookup;
					end else if (in_last) begin
						nxt_r.code = st_short_frame;
						nxt_r.st = s_status;
					end
				end
			end
			s_lookup: begin
				nxt_r.sock = any_hit ? hit_idx : free_idx;
				if (r_ff.proto != proto_udp && r_ff.proto != proto_tcp &&
					r_ff.proto != proto_tls) begin
					nxt_r.code = st_bad_proto;
				end else if (any_hit) begin
					nxt_r.st = s_payload;
				end else if (r_ff.sport != 16'h0000) begin
					nxt_r.code = st_no_socket;
				end else if (!any_free) begin
					nxt_r.code = st_no_free;
				end else begin
					nxt_r.st = s_open;
				end
				if (nxt_r.code != st_ok) begin
					nxt_r.st = r_ff.ended ? s_status : s_drain;
				end
			end
			s_open: begin
				if (net_open_done) begin
					if (net_open_ok) begin
						nxt_r.st = s_payload;
					end else begin
						nxt_r.code = st_open_fail;
						nxt_r.st = r_ff.ended ? s_status : s_drain;
					end
				end
			end
			s_payload: begin
				if (in_take) begin
					if (r_ff.cnt == limit) begin
						// a byte past the limit: tell the stack to drop it all
						nxt_r.code = st_too_long;
						nxt_r.abort = 1'b1;
						nxt_r.st = in_last ? s_status : s_drain;
					end else begin
						nxt_r.cnt = r_ff.cnt + 11'h001;
						nxt_r.txv = 1'b1;
						nxt_r.txd = in_data;
						nxt_r.txl = in_last;
						nxt_r.ended = in_last;
					end
				end else if (r_ff.ended && !r_ff.txv) begin
					nxt_r.st = close_wanted ? s_close : s_status;
				end
			end
			s_close: begin
				if (net_close_done) begin
					nxt_r.st = s_status;
				end
			end
			s_drain: begin
				if (in_take && in_last) begin
					nxt_r.st = s_status;
				end
			end
			s_status: begin
				// frame id zero means the host wants no status at all
				if (r_ff.fid == 8'h00 || stat_ready) begin
					nxt_r.st = s_idle;
				end
			end
			default: begin
				nxt_r.st = s_idle;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_ff <= '0;
		end else if (ce) begin
			r_ff <= nxt_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	assign net_open_req = r_ff.st == s_open;
	assign net_open_addr = r_ff.addr;
	assign net_open_port = r_ff.dport;
	assign net_open_proto = r_ff.proto;
	assign net_open_tls = r_ff.proto == proto_tls;
	assign net_open_tls_profile = tls_profile_first;
	assign net_tx_valid = r_ff.txv;
	assign net_tx_data = r_ff.txd;
	assign net_tx_last = r_ff.txl;
	assign net_tx_sock = r_ff.sock;
	assign net_tx_abort = r_ff.abort;
	assign net_close_req = r_ff.st == s_close;
	assign host_rx_valid = r_ff.rxv;
	assign host_rx_data = r_ff.rxd;
	assign host_rx_last = r_ff.rxl;
	assign host_rx_sock = r_ff.rxs;
	assign stat_valid = r_ff.st == s_status && r_ff.fid != 8'h00;
	assign stat_frame_id = r_ff.fid;
	assign stat_code = r_ff.code;
endmodule : ipv4_transmit_request_handler
`default_nettype wire

//--- bench/ipv4_tx_checker.sv
/*
 * port checker for the ipv4 transmit request handler.
 * assumes the single clock domain and active high rst of the top.
 */
`timescale 1ns/1ps
`default_nettype none
module ipv4_tx_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_ready,
	input wire logic net_open_req,
	input wire logic [7:0] net_open_proto,
	input wire logic net_open_tls,
	input wire logic [1:0] net_open_tls_profile,
	input wire logic net_tx_valid,
	input wire logic net_tx_ready,
	input wire logic [7:0] net_tx_data,
	input wire logic net_close_req,
	input wire logic net_close_done,
	input wire logic net_rx_valid,
	input wire logic net_rx_ready,
	input wire logic [7:0] net_rx_data,
	input wire logic host_rx_valid,
	input wire logic [7:0] host_rx_data,
	input wire logic stat_valid,
	input wire logic stat_ready,
	input wire logic [7:0] stat_frame_id,
	input wire logic [7:0] stat_code
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_tls_flag: assert property (net_open_req |->
		net_open_tls == (net_open_proto == 8'h04)) else $error("tls flag");
	chk_tls_slot: assert property (net_open_req |->
		net_open_tls_profile == 2'h0) else $error("tls profile");
	chk_quiet_id: assert property (stat_valid |->
		stat_frame_id != 8'h00) else $error("status for id zero");
	chk_stat_hold: assert property (stat_valid && !stat_ready |=>
		stat_valid && $stable(stat_code)) else $error("status dropped");
	chk_open_gate: assert property (net_open_req |->
		!in_ready) else $error("bytes taken before open");
	chk_close_udp: assert property (net_close_req |->
		net_open_proto != 8'h00) else $error("udp close");
	chk_close_wait: assert property (net_close_req && !net_close_done
		|=> net_close_req) else $error("close dropped");
	chk_tx_hold: assert property (net_tx_valid && !net_tx_ready |=>
		net_tx_valid && $stable(net_tx_data)) else $error("tx byte lost");
	chk_rx_fwd: assert property ($rose(host_rx_valid) |->
		$past(net_rx_valid && net_rx_ready) && host_rx_data ==
		$past(net_rx_data)) else $error("rx byte not forwarded");
endmodule : ipv4_tx_checker
bind ipv4_transmit_request_handler ipv4_tx_checker i_chk (.clk, .rst,
	.in_ready, .net_open_req, .net_open_proto, .net_open_tls,
	.net_open_tls_profile, .net_tx_valid, .net_tx_ready, .net_tx_data,
	.net_close_req, .net_close_done, .net_rx_valid, .net_rx_ready,
	.net_rx_data, .host_rx_valid, .host_rx_data, .stat_valid, .stat_ready,
	.stat_frame_id, .stat_code);
`default_nettype wire

//--- bench/net_stack_model.sv
/*
 * network stack stand-in: answers open and close after a few cycles and
 * stalls tx when slow; refuses opens while fail is high.
 * assumes requests hold until answered.
 */
`timescale 1ns/1ps
`default_nettype none
module net_stack_model #(
	parameter logic [15:0] lport = 16'hc000
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic fail,
	input wire logic net_open_req,
	input wire logic net_close_req,
	output logic net_open_done,
	output logic net_open_ok,
	output logic [15:0] net_open_local_port,
	output logic net_tx_ready,
	output logic net_close_done
);
	logic [2:0] dly_ff;
	logic busy;
	assign busy = (net_open_req || net_close_req) && !net_open_done;
	// outside the done pulse the port and ok carry junk on purpose
	assign net_open_ok = net_open_done ? !fail : dly_ff[0];
	assign net_open_local_port = net_open_done ? lport : ~lport;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dly_ff <= 3'h0;
			net_open_done <= 1'b0;
			net_close_done <= 1'b0;
			net_tx_ready <= 1'b0;
		end else begin
			dly_ff <= (busy && !net_close_done) ? dly_ff + 3'h1 : 3'h0;
			net_open_done <= net_open_req && dly_ff == 3'h3;
			net_close_done <= net_close_req && dly_ff == 3'h3;
			net_tx_ready <= !slow || !net_tx_ready;
		end
	end
endmodule : net_stack_model
`default_nettype wire

//--- bench/ipv4_transmit_request_handler_tb.sv
/*
 * testbench for the ipv4 transmit request handler with a stack model.
 * assumes status and payload settle within 60 cycles of a frame's end.
 */
`timescale 1ns/1ps
`default_nettype none
`define cmp(a, b) begin \
	n_compared++; \
	if ((a) !== (b)) begin \
		err_total++; \
		$display("mismatch t=%0t got %0h exp %0h", $time, (a), (b)); \
	end \
end
module ipv4_transmit_request_handler_tb import ipv4_tx_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, slow = 1'b0;
	logic in_valid = 1'b0, in_last = 1'b0, net_rx_valid = 1'b0;
	logic net_rx_last = 1'b0, net_sock_closed = 1'b0;
	logic stat_ready = 1'b1, host_rx_ready = 1'b1, fail = 1'b0;
	logic [7:0] in_data = 8'h00, net_rx_data = 8'h00, st_id, st_code;
	logic [1:0] net_rx_sock = 2'h0, net_sock_closed_idx = 2'h0;
	logic in_ready, net_open_req, net_open_tls, net_open_done, net_open_ok;
	logic net_tx_valid, net_tx_ready, net_tx_last, net_tx_abort, tls_seen;
	logic net_close_req, net_close_done, net_rx_ready, host_rx_valid;
	logic host_rx_last, stat_valid, rx_lst;
	logic [31:0] net_open_addr, op_addr;
	logic [15:0] net_open_port, net_open_local_port, op_port;
	logic [7:0] net_open_proto, net_tx_data, host_rx_data;
	logic [7:0] stat_frame_id, stat_code;
	logic [1:0] net_open_tls_profile, net_tx_sock, host_rx_sock, tx_sk, rx_sk;
	logic [7:0] tx_q[$], rx_q[$];
	int err_total = 0, n_compared = 0, n_stat = 0, n_open = 0, n_close = 0;
	int n_abort = 0, n_txl = 0;
	ipv4_transmit_request_handler #(.num_sock(4)) i_dut (.clk, .rst, .ce,
		.in_valid, .in_ready, .in_data, .in_last, .net_open_req,
		.net_open_addr, .net_open_port, .net_open_proto, .net_open_tls,
		.net_open_tls_profile, .net_open_done, .net_open_ok,
		.net_open_local_port, .net_tx_valid, .net_tx_ready, .net_tx_data,
		.net_tx_last, .net_tx_sock, .net_tx_abort, .net_close_req,
		.net_close_done, .net_sock_closed, .net_sock_closed_idx,
		.net_rx_valid, .net_rx_ready, .net_rx_data, .net_rx_last,
		.net_rx_sock, .host_rx_valid, .host_rx_ready, .host_rx_data,
		.host_rx_last, .host_rx_sock, .stat_valid, .stat_ready,
		.stat_frame_id, .stat_code);
	net_stack_model i_net (.clk, .rst, .slow, .net_open_req, .net_close_req,
		.net_open_done, .net_open_ok, .net_open_local_port, .net_tx_ready,
		.net_close_done, .fail);
	always #25 clk = ~clk;
	always @(negedge clk) begin
		stat_ready <= !slow || !stat_ready;
		host_rx_ready <= !slow || !host_rx_ready;
	end
	always @(posedge clk) begin
		if (net_tx_valid && net_tx_ready) begin
			tx_q.push_back(net_tx_data);
			tx_sk = net_tx_sock;
			if (net_tx_last) n_txl++;
		end
		if (host_rx_valid && host_rx_ready) begin
			rx_q.push_back(host_rx_data);
			rx_sk = host_rx_sock;
			rx_lst = host_rx_last;
		end
		if (net_open_req && net_open_done) begin
			n_open++;
			tls_seen = net_open_tls;
			op_addr = net_open_addr;
			op_port = net_open_port;
		end
		if (net_close_req && net_close_done) n_close++;
		if (net_tx_abort) n_abort++;
		if (stat_valid && stat_ready) begin
			n_stat++;
			st_id = stat_frame_id;
			st_code = stat_code;
		end
	end
	//////////////////////////////////////////////////////////////////////
	task automatic send(input logic [7:0] id, d, pr, op, ex,
		input logic [15:0] sp, input int len);
		logic [7:0] b[$];
		int s0, k, l0;
		b = {id, 8'h0a, 8'h00, 8'h00, d, 8'h1f, 8'h90, sp[15:8], sp[7:0], pr, op};
		// a negative length cuts the header short by that many bytes
		if (len < 0) b = b[0:10+len];
		for (int i = 0; i < len; i++) b.push_back(i[7:0]);
		tx_q = {};
		s0 = n_stat;
		l0 = n_txl;
		foreach (b[i]) begin
			in_valid = 1'b1;
			in_data = b[i];
			in_last = (i == b.size() - 1);
			while (!in_ready) @(negedge clk);
			@(negedge clk);
		end
		in_valid = 1'b0;
		in_last = 1'b0;
		k = 0;
		while (n_stat == s0 && k < 60) begin
			@(negedge clk);
			k++;
		end
		if (id != 8'h00) begin
			`cmp(st_id, id)
			`cmp(st_code, ex)
		end else `cmp(n_stat, s0)
		if (ex == st_ok) begin
			`cmp(tx_q.size(), len)
			`cmp(n_txl, l0 + 1)
			foreach (tx_q[i]) `cmp(tx_q[i], i[7:0])
		end
	endtask : send
	task automatic t_new();
		int o0 = n_open, c0 = n_close;
		send(8'h05, 8'h01, proto_tcp, 8'h02, st_ok, 16'h0, 3);
		`cmp(n_open, o0 + 1)
		`cmp(op_addr, 32'h0a000001)
		`cmp(op_port, 16'h1f90)
		`cmp(tx_sk, 2'h0)
		`cmp(n_close, c0 + 1)
		$display("t_new done");
	endtask : t_new
	task automatic t_udp();
		int o0 = n_open, c0 = n_close;
		send(8'h00, 8'h02, proto_udp, 8'h02, st_ok, 16'h0, 4);
		slow = 1'b1;
		send(8'h07, 8'h02, proto_udp, 8'h00, st_ok, 16'h0, 6);
		slow = 1'b0;
		`cmp(n_open, o0 + 1)
		`cmp(n_close, c0)
		send(8'h08, 8'h02, proto_udp, 8'h00, st_no_socket, 16'h1234, 2);
		send(8'h09, 8'h02, proto_udp, 8'h00, st_ok, 16'hc000, 2);
		`cmp(n_open, o0 + 1)
		$display("t_udp done");
	endtask : t_udp
	task automatic t_tls();
		send(8'h0b, 8'h03, proto_tls, 8'h00, st_ok, 16'h0, 2);
		`cmp(tls_seen, 1'b1)
		`cmp(tx_sk, 2'h1)
		send(8'h0c, 8'h03, 8'h02, 8'h00, st_bad_proto, 16'h0, 2);
		$display("t_tls done");
	endtask : t_tls
	task automatic t_limits();
		int a0 = n_abort;
		send(8'h11, 8'h04, proto_tcp, 8'h00, st_ok, 16'h0, 1500);
		send(8'h12, 8'h04, proto_tcp, 8'h00, st_too_long, 16'h0, 1501);
		send(8'h13, 8'h02, proto_udp, 8'h00, st_ok, 16'h0, 512);
		send(8'h14, 8'h02, proto_udp, 8'h00, st_too_long, 16'h0, 513);
		`cmp(n_abort, a0 + 2)
		$display("t_limits done");
	endtask : t_limits
	task automatic t_slots();
		int o0 = n_open;
		fail = 1'b1;
		send(8'h15, 8'h05, proto_tcp, 8'h00, st_open_fail, 16'h0, 2);
		fail = 1'b0;
		send(8'h16, 8'h05, proto_tcp, 8'h00, st_ok, 16'h0, 2);
		`cmp(tx_sk, 2'h3)
		send(8'h17, 8'h06, proto_tcp, 8'h00, st_no_free, 16'h0, 2);
		// the stack drops a socket by itself, as its idle timeout would
		net_sock_closed = 1'b1;
		net_sock_closed_idx = 2'h3;
		@(negedge clk);
		net_sock_closed = 1'b0;
		send(8'h18, 8'h06, proto_tcp, 8'h00, st_ok, 16'h0, 2);
		`cmp(tx_sk, 2'h3)
		send(8'h19, 8'h06, proto_tcp, 8'h00, st_short_frame, 16'h0, -5);
		`cmp(n_open, o0 + 3)
		$display("t_slots done");
	endtask : t_slots
	task automatic t_rx();
		int k = 0;
		rx_q = {};
		slow = 1'b1;
		for (int i = 0; i < 3; i++) begin
			net_rx_valid = 1'b1;
			net_rx_data = 8'h50 + i[7:0];
			net_rx_last = (i == 2);
			// host ready moves on the falling edge, so judge it at the rising one
			do @(posedge clk); while (!net_rx_ready);
			@(negedge clk);
		end
		net_rx_valid = 1'b0;
		while (rx_q.size() < 3 && k < 20) begin
			@(negedge clk);
			k++;
		end
		slow = 1'b0;
		`cmp(rx_q.size(), 3)
		foreach (rx_q[i]) `cmp(rx_q[i], 8'h50 + i[7:0])
		`cmp(rx_sk, 2'h0)
		`cmp(rx_lst, 1'b1)
		$display("t_rx done");
	endtask : t_rx
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	//////////////////////////////////////////////////////////////////////
	initial begin
		#1000000;
		err_total++;
		complete_run();
	end
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_new();
		t_udp();
		t_tls();
		t_limits();
		t_slots();
		t_rx();
		complete_run();
	end
endmodule : ipv4_transmit_request_handler_tb
`default_nettype wire
